/* File: logic/dram_refresh_controller.sv */
// DRAM refresh controller: inserts refresh cycles at bus boundaries.
// Assumes the bus sequencer reports its state each clock and stalls
// while refresh_busy_out is high.
// Functional notes
// RQ1: DMA cycles refreshed like CPU cycles
// RQ2: Refresh starts only at a bus boundary
// RQ3: Interval and length set by software
// RQ4: Refresh length two or three clocks
// RQ5: Eight-bit row address driven during refresh
// RQ6: Opcode fetch counter independent of refresh
// RQ7: Refresh allowed between two internal cycles
// RQ8: Refresh allowed between internal and machine cycle
// RQ9: Refresh follows only T3 or internal
// RQ10: Enabled refresh continues in emulator wait
// RQ11: Disabled refresh stops emulator wait, not trace
// RQ12: Request held pending until boundary, then cleared
`timescale 1ns/1ps
module dram_refresh_controller
   import refresh_pkg::*;
(
   input  wire logic                    clk_in,
   input  wire logic                    rst_n_in,
   input  wire refresh_pkg::refresh_cfg_t cfg_in,
   input  wire refresh_pkg::bus_state_t state_in,
   input  wire logic                    dma_owner_in,
   input  wire logic                    emu_wait_in,
   input  wire logic                    emu_trace_in,
   input  wire logic                    opcode_fetch_in,
   output refresh_pkg::refresh_bus_t    refresh_out,
   output logic                         refresh_busy_out,
   output logic [7:0]                   fetch_count_out
);
   // Refresh cycle phases; TR3 is used only by the long setting
   typedef enum logic [1:0] {IDLE, TR1, TR2, TR3} ref_state_t;

   // Sequencer state, timer, and decoded handshake terms
   ref_state_t              state_r;
   logic [INTERVAL_W-1:0]   tick_r;
   logic                    pending_r;
   logic                    long_r;       // Length latched at start
   logic                    boundary;
   logic                    machine_end;
   logic                    internal_end;
   logic                    interval_hit;
   logic                    run_ok;
   logic                    start;
   logic                    finish;
   logic [ADDR_W-1:0]       row;

   // RQ9 legal end states
   // A machine cycle ends in T3; T1, T2 and wait states never end one
   assign machine_end  = (state_in == ST_T3);
   // RQ7 internal cycle ends
   // Each internal state is a boundary, so refresh fits between two of them
   assign internal_end = (state_in == ST_TI);
   // RQ1 DMA same as CPU
   // Bus owner deliberately unread: a DMA machine cycle also ends in T3
   assign boundary     = machine_end || internal_end;

   // RQ10 enabled refresh always runs
   // RQ11 disabled only during trace
   // With the enable bit low, refresh runs only while the emulator traces;
   // in command wait and in normal running it stays off
   assign run_ok       = cfg_in.enable || emu_trace_in;

   // RQ2 start at boundary
   // RQ8 internal then machine cycle
   // A request waits in pending_r and is taken at the first boundary at
   // which refresh may run and no refresh cycle is under way
   assign start        = pending_r && boundary && run_ok && (state_r == IDLE);

   // RQ12 interval elapsed
   // Spacing is the programmed count plus one boundaries
   assign interval_hit = boundary && (state_r == IDLE) && (tick_r >= cfg_in.interval);

   // RQ4 length select
   // Latched length, so a setting changed mid-refresh cannot stretch it
   assign finish       = (state_r == TR2 && !long_r) || (state_r == TR3);

   // RQ3 programmable interval timer
   // Counts boundaries rather than clocks, so spacing follows bus activity;
   // a smaller interval written while counting takes effect at once
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         tick_r <= '0;
      end else if (boundary && state_r == IDLE) begin
         tick_r <= interval_hit ? '0 : tick_r + INTERVAL_W'(1);
      end
   end

   // RQ12 request held until done
   // Set and clear cannot meet: set needs IDLE, clear needs TR2 or TR3
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pending_r <= 1'b0;
      end else if (interval_hit) begin
         pending_r <= 1'b1;
      end else if (finish) begin
         pending_r <= 1'b0;
      end
   end

   // RQ3 length taken at start
   // Software may rewrite the setting at any time; the cycle under way keeps its length
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         long_r <= 1'b0;
      end else if (start) begin
         long_r <= cfg_in.long_cycle;
      end
   end

   // Refresh cycle sequencer
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_r <= IDLE;
      end else begin
         case (state_r)
            IDLE: begin
               if (start) begin
                  state_r <= TR1;
               end
            end
            TR1: state_r <= TR2;
            // RQ4 third clock if long
            TR2: state_r <= long_r ? TR3 : IDLE;
            TR3: state_r <= IDLE;
            default: state_r <= IDLE;
         endcase
      end
   end

   // RQ5 row counter advances per refresh
   row_counter #(.W(ADDR_W)) u_row (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .step_in  (finish),
      .row_out  (row)
   );

   // Registered outputs toward memory
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         refresh_out      <= '0;
         refresh_busy_out <= 1'b0;
      end else begin
         refresh_busy_out   <= start || (state_r != IDLE && !finish);
         refresh_out.active <= start || (state_r != IDLE && !finish);
         refresh_out.strobe <= start;
         // RQ5 row address on bus
         refresh_out.row    <= row;
      end
   end

   // RQ6 opcode fetch count, no refresh influence
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         fetch_count_out <= 8'h00;
      end else if (opcode_fetch_in) begin
         fetch_count_out <= fetch_count_out + 8'h01;
      end
   end

   // Assertions on the design's own signals
   // Placement of refresh cycles
   a_start_boundary: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ2
      start |-> (state_in == ST_T3 || state_in == ST_TI))
      else $error("refresh start off boundary");
   a_no_mid_cycle: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ9
      (state_in == ST_T1 || state_in == ST_T2 || state_in == ST_TW) |-> !start)
      else $error("refresh inside machine cycle");
   a_dma_same: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ1
      (pending_r && boundary && cfg_in.enable && state_r == IDLE && dma_owner_in) |=> refresh_out.strobe)
      else $error("dma cycle blocked refresh");

   // Length and row address
   a_len_two: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ4
      (start && !cfg_in.long_cycle) |=> refresh_out.active ##1 refresh_out.active ##1 !refresh_out.active)
      else $error("two clock length wrong");
   a_len_three: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ4
      (start && cfg_in.long_cycle) |=> refresh_out.active [*3] ##1 !refresh_out.active)
      else $error("three clock length wrong");
   a_row_step: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ5
      finish |=> row == $past(row) + 8'h01)
      else $error("row not advanced");
   a_row_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ5
      (refresh_out.active && !refresh_out.strobe) |-> $stable(refresh_out.row))
      else $error("row moved during refresh");

   // Gating by mode
   a_emu_off: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ11
      (!cfg_in.enable && emu_wait_in && !emu_trace_in) |-> !start)
      else $error("refresh in emulator wait");
   a_emu_on: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ10
      (cfg_in.enable && emu_wait_in && pending_r && boundary && state_r == IDLE) |=> refresh_out.strobe)
      else $error("enabled refresh stalled");
   a_quiet_off: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ11
      (!cfg_in.enable && !emu_trace_in) |-> !start)
      else $error("refresh while disabled");

   // Request and output bookkeeping
   a_pending_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ12
      (pending_r && !finish) |=> pending_r)
      else $error("pending lost");
   a_pending_set: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ12
      interval_hit |=> pending_r)
      else $error("elapsed interval not pending");
   a_strobe_pulse: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ2
      refresh_out.strobe |=> !refresh_out.strobe)
      else $error("strobe longer than one clock");
   a_busy_match: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ9
      refresh_busy_out == refresh_out.active)
      else $error("busy and active differ");
   a_fetch_count: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ6
      !opcode_fetch_in |=> fetch_count_out == $past(fetch_count_out))
      else $error("fetch count moved");

   // Cover points for the main scenarios
   c_refresh_t3: cover property (@(posedge clk_in) start && state_in == ST_T3);
   c_refresh_ti: cover property (@(posedge clk_in) start && state_in == ST_TI);
   c_refresh_dma: cover property (@(posedge clk_in) start && dma_owner_in);
   c_refresh_long: cover property (@(posedge clk_in) start && cfg_in.long_cycle);
   c_refresh_wait: cover property (@(posedge clk_in) start && emu_wait_in);
endmodule

/* File: logic/refresh_pkg.sv */
// Refresh controller constants and carrier types.
// Assumes a single 25 MHz system clock domain.
package refresh_pkg;
   localparam int          ADDR_W        = 8;
   localparam int          INTERVAL_W    = 8;
   localparam logic [7:0]  INTERVAL_RST  = 8'h0A;  // Reset refresh spacing, in boundaries
   localparam logic [7:0]  ADDR_RST      = 8'h00;
   localparam logic [1:0]  LEN_TWO       = 2'h2;   // Two clock refresh cycle
   localparam logic [1:0]  LEN_THREE     = 2'h3;   // Three clock refresh cycle
   localparam logic        ENABLE_RST    = 1'h1;

   // Bus state reported by the sequencer each clock
   typedef enum logic [2:0] {ST_T1, ST_T2, ST_TW, ST_T3, ST_TI} bus_state_t;

   // Software configuration of the refresh logic
   typedef struct packed {
      logic                  enable;
      logic                  long_cycle;   // 1 selects three clocks
      logic [INTERVAL_W-1:0] interval;
   } refresh_cfg_t;

   // Refresh cycle presented to external memory
   typedef struct packed {
      logic              active;
      logic              strobe;
      logic [ADDR_W-1:0] row;
   } refresh_bus_t;
endpackage

/* File: logic/row_counter.sv */
// Eight-bit refresh row counter, advanced once per refresh cycle.
// Assumes step_in is a one-cycle pulse on clk_in.
`timescale 1ns/1ps
module row_counter #(
   parameter int W = 8
) (
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   input  wire logic         step_in,
   output logic [W-1:0]      row_out
);
   // Independent of any opcode fetch count by construction
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         row_out <= '0;
      end else if (step_in) begin
         row_out <= row_out + W'(1);
      end
   end
endmodule

/* File: sim/dram_model.sv */
// Far-side memory model: latches each refresh row.
// Assumes the refresh carrier of refresh_pkg.
`timescale 1ns/1ps
module dram_model
   import refresh_pkg::*;
(
   input  wire logic                      clk_in,
   input  wire refresh_pkg::refresh_bus_t bus_in,
   output logic [7:0]                     row_out,
   output int                             hits_out
);
   initial hits_out = 0;
   // Row taken on strobe only; bench counts hits per phase
   always @(posedge clk_in) begin
      if (bus_in.strobe === 1'b1) begin
         row_out  <= bus_in.row;
         hits_out <= hits_out + 1;
      end
   end
endmodule

/* File: sim/tb_top.sv */
// Random bus traffic against the refresh controller.
// Assumes the sequencer holds its state while busy is high.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; $display("MISMATCH t=%0t bad value", $time); end end
module tb_top;
   import refresh_pkg::*;
   logic         clk_in = 0, rst_n_in = 0, dma_owner_in = 0, emu_wait_in = 0;
   logic         emu_trace_in = 0, opcode_fetch_in = 0, lng_q = 0;
   refresh_cfg_t cfg_in = '0;
   bus_state_t   state_in = ST_TI, prev_state = ST_TI;
   refresh_bus_t refresh_out;
   logic         refresh_busy_out;
   logic [7:0]   fetch_count_out, model_row, exp_row = 8'h00, exp_fetch = 8'h00;
   int           fails = 0, num_checks = 0, hits, run = 0, exp_len = 2, na, nb;
   bit           idle_only = 0, chk_model = 0;
   dram_model u_mem (.clk_in(clk_in), .bus_in(refresh_out), .row_out(model_row), .hits_out(hits));
   dram_refresh_controller u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .cfg_in(cfg_in), .state_in(state_in),
      .dma_owner_in(dma_owner_in), .emu_wait_in(emu_wait_in), .emu_trace_in(emu_trace_in),
      .opcode_fetch_in(opcode_fetch_in), .refresh_out(refresh_out), .refresh_busy_out(refresh_busy_out),
      .fetch_count_out(fetch_count_out));
   initial forever #20 clk_in = ~clk_in;
   // Legal machine-cycle order: T1 T2 [TW] T3, or idle states
   function automatic bus_state_t next_state(bus_state_t s);
      case (s)
         ST_T1:   return ST_T2;
         ST_T2:   return ($urandom % 2) ? ST_TW : ST_T3;
         ST_TW:   return ST_T3;
         default: return (idle_only || ($urandom % 2)) ? ST_TI : ST_T1;
      endcase
   endfunction
   function automatic int len_of(logic lng);
      return lng ? int'(LEN_THREE) : int'(LEN_TWO);
   endfunction
   // Stimulus and expected fetch count at the same edge
   always @(posedge clk_in) begin
      prev_state <= state_in;
      lng_q <= cfg_in.long_cycle;
      opcode_fetch_in <= ($urandom % 4 == 0);
      if (!rst_n_in) exp_fetch <= 8'h00;
      else if (opcode_fetch_in) exp_fetch <= exp_fetch + 8'h01;
      if (refresh_busy_out !== 1'b1) state_in <= next_state(state_in);
   end
   // Checks on settled outputs
   always @(negedge clk_in) if (rst_n_in) begin
      `CHK(refresh_busy_out, refresh_out.active)
      `CHK(fetch_count_out, exp_fetch)
      // Memory model latched the row one clock after the strobe
      if (chk_model) `CHK(model_row, exp_row - 8'h01)
      chk_model = (refresh_out.strobe === 1'b1);
      if (refresh_out.strobe === 1'b1) begin
         `CHK(refresh_out.row, exp_row)
         `CHK(prev_state inside {ST_T3, ST_TI}, 1'b1)
         exp_row++;
         exp_len = len_of(lng_q);
      end
      if (refresh_out.active === 1'b1) run++;
      else if (run > 0) begin
         `CHK(run, exp_len)
         run = 0;
      end
   end
   task automatic phase(input bit en, lng, wt, tr, dma, idl, input logic [7:0] iv, output int n);
      int h0;
      @(posedge clk_in);
      cfg_in <= '{en, lng, iv};
      emu_wait_in <= wt;
      emu_trace_in <= tr;
      dma_owner_in <= dma;
      idle_only = idl;
      repeat (8) @(posedge clk_in);
      h0 = hits;
      repeat (600) @(posedge clk_in);
      n = hits - h0;
   endtask
   task automatic end_sim;
      $display("checks=%0d fails=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #400000;
      fails++;
      end_sim;
   end
   initial begin
      void'($urandom(94));
      repeat (4) @(posedge clk_in);
      rst_n_in <= 1'b1;
      phase(1, 0, 0, 0, 0, 0, 8'h04, na);
      `CHK(na > 0, 1'b1)
      phase(1, 1, 0, 0, 1, 0, 8'h04, na);
      `CHK(na > 0, 1'b1)
      phase(1, 0, 0, 0, 0, 1, 8'h04, na);
      phase(1, 0, 0, 0, 0, 1, 8'h28, nb);
      `CHK(na > nb && nb > 0, 1'b1)
      phase(1, 1, 1, 0, 0, 0, 8'h04, na);
      `CHK(na > 0, 1'b1)
      phase(0, 0, 1, 0, 0, 0, 8'h04, na);
      `CHK(na, 0)
      phase(0, 1, 1, 1, 1, 0, 8'h04, na);
      `CHK(na > 0, 1'b1)
      end_sim;
   end
endmodule
